// *** rtl/sdfc_consts.vh ***
// Register offsets, field positions, reset values and timing counts.
// Included by every design file of the converter back end.
`ifndef SDFC_CONSTS_VH
`define SDFC_CONSTS_VH
`define SDFC_OFF_MODE     12'h000
`define SDFC_OFF_STATUS   12'h004
`define SDFC_OFF_RATE     12'h008
`define SDFC_OFF_PRI_CFG  12'h00c
`define SDFC_OFF_AUX_CFG  12'h010
`define SDFC_OFF_PRI_DATA 12'h014
`define SDFC_OFF_AUX_DATA 12'h018
`define SDFC_OFF_PRI_OFS  12'h01c
`define SDFC_OFF_PRI_GAIN 12'h020
`define SDFC_OFF_AUX_OFS  12'h024
`define SDFC_OFF_AUX_GAIN 12'h028
`define SDFC_RATE_RST     8'h45
`define SDFC_RATE_MIN     8'h0d
`define SDFC_RATE_CAL     8'hff
`define SDFC_MODE_RST     8'h00
`define SDFC_MODE_POS_PRI_EN  5
`define SDFC_MODE_POS_AUX_EN  4
`define SDFC_MODE_MSB     2
`define SDFC_MD_IDLE      3'h0
`define SDFC_MD_SINGLE    3'h2
`define SDFC_MD_CONT      3'h3
`define SDFC_MD_INT_ZERO  3'h4
`define SDFC_MD_INT_FULL  3'h5
`define SDFC_MD_SYS_ZERO  3'h6
`define SDFC_MD_SYS_FULL  3'h7
`define SDFC_CFG_POS_UNI  0
`define SDFC_ST_POS_PRI_DONE 7
`define SDFC_ST_POS_AUX_DONE 6
`define SDFC_ST_POS_NOREF 4
`define SDFC_ST_POS_PRI_ERR 3
`define SDFC_ST_POS_AUX_ERR 2
`define SDFC_DEC_PER_RATE 8
`define SDFC_OFS_FACTORY  16'h8000
`define SDFC_GAIN_FACTORY 16'h8000
`endif

// *** rtl/sdfc_sinc3.v ***
// Third-order sinc decimator with output-rate control.
// Assumes one modulator bit per clock, already synchronised.
`timescale 1ns/1ps
`include "sdfc_consts.vh"
module sdfc_sinc3 #(
  parameter OUT_W = 16
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             run,
  input  wire             bit_in,
  input  wire [7:0]       rate,
  output reg  [OUT_W-1:0] word_out,
  output reg              word_valid
);
  localparam AW = 36;
  reg  [AW-1:0] i1_reg, i2_reg, i3_reg;
  reg  [AW-1:0] d1_reg, d2_reg, d3_reg;
  reg  [15:0]   cnt_reg;
  wire [15:0]   dec = {5'h00, rate, 3'h0};
  wire [AW-1:0] c1 = i3_reg - d1_reg;
  wire [AW-1:0] c2 = c1 - d2_reg;
  wire [AW-1:0] c3 = c2 - d3_reg;
  // Full scale is dec cubed, just under 2**33 at the slowest rate.
  wire [AW-1:0] sc = c3 >> 17;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i1_reg <= {AW{1'b0}};
      i2_reg <= {AW{1'b0}};
      i3_reg <= {AW{1'b0}};
      d1_reg <= {AW{1'b0}};
      d2_reg <= {AW{1'b0}};
      d3_reg <= {AW{1'b0}};
      cnt_reg <= 16'h0000;
      word_out <= {OUT_W{1'b0}};
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (!run) begin
        i1_reg <= {AW{1'b0}};
        i2_reg <= {AW{1'b0}};
        i3_reg <= {AW{1'b0}};
        d1_reg <= {AW{1'b0}};
        d2_reg <= {AW{1'b0}};
        d3_reg <= {AW{1'b0}};
        cnt_reg <= 16'h0000;
      end else begin
        i1_reg <= i1_reg + {{(AW-1){1'b0}}, bit_in};
        i2_reg <= i2_reg + i1_reg;
        i3_reg <= i3_reg + i2_reg;
        if (cnt_reg >= dec - 16'h0001) begin
          cnt_reg <= 16'h0000;
          d1_reg <= i3_reg;
          d2_reg <= c1;
          d3_reg <= c2;
          word_out <= (sc[AW-1:OUT_W] != 0) ? {OUT_W{1'b1}}
                                            : sc[OUT_W-1:0];
          word_valid <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule

// *** rtl/sdfc_channel.v ***
// One converter: chop control, averaging, correction and calibration.
// Assumes filter words arrive as single-cycle strobes.
`timescale 1ns/1ps
`include "sdfc_consts.vh"
module sdfc_channel (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        enable,
  input  wire [2:0]  mode,
  input  wire        unipolar,
  input  wire        no_ref,
  input  wire        bit_in,
  input  wire [7:0]  rate,
  output reg         chop_swap,
  output wire        ref_route,
  output reg  [15:0] result,
  output reg  [15:0] ofs_coef,
  output reg  [15:0] gain_coef,
  output reg         done,
  output reg         cal_err
);
  wire        cal = mode[2];
  wire        run = enable && mode != `SDFC_MD_IDLE;
  wire [7:0]  eff_rate = cal ? `SDFC_RATE_CAL : rate;
  wire [15:0] fw;
  wire        fv;
  reg  [15:0] prev_reg;
  reg  [1:0]  fill_reg;
  reg  [2:0]  last_mode_reg;
  reg         err_seen_reg;
  assign ref_route = enable && (mode == `SDFC_MD_INT_ZERO ||
                                mode == `SDFC_MD_INT_FULL);
  sdfc_sinc3 #(.OUT_W(16)) u_filt (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .run        (run && mode == last_mode_reg),
    .bit_in     (bit_in ^ chop_swap),
    .rate       (eff_rate),
    .word_out   (fw),
    .word_valid (fv)
  );
  wire [16:0] sum  = {1'b0, fw} + {1'b0, prev_reg};
  wire [15:0] avg  = sum[16:1];
  wire [17:0] diff = {2'b00, avg} - {2'b00, ofs_coef} + 18'h08000;
  wire [15:0] dcl  = diff[17] ? 16'h0000 :
                     diff[16] ? 16'hffff : diff[15:0];
  wire [31:0] prod = dcl * gain_coef;
  wire [16:0] scl  = prod[31:15];
  wire [15:0] bip  = (scl[16]) ? 16'hffff : scl[15:0];
  wire [15:0] corr = unipolar ? (bip[15] ? {bip[14:0], 1'b0} : 16'h0000)
                              : bip;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chop_swap <= 1'b0;
      prev_reg <= 16'h0000;
      fill_reg <= 2'h0;
      last_mode_reg <= `SDFC_MD_IDLE;
      result <= 16'h0000;
      ofs_coef <= `SDFC_OFS_FACTORY;
      gain_coef <= `SDFC_GAIN_FACTORY;
      done <= 1'b0;
      cal_err <= 1'b0;
      err_seen_reg <= 1'b0;
    end else begin
      last_mode_reg <= mode;
      done <= 1'b0;
      if (!run || mode != last_mode_reg) begin
        fill_reg <= 2'h0;
        chop_swap <= 1'b0;
        err_seen_reg <= 1'b0;
        if (cal && run)
          cal_err <= 1'b0;
      end else begin
        if (cal && no_ref)
          err_seen_reg <= 1'b1;
        if (fv) begin
          chop_swap <= ~chop_swap;
          prev_reg <= fw;
          if (fill_reg != 2'h2)
            fill_reg <= fill_reg + 2'h1;
          if (fill_reg != 2'h0) begin
            done <= 1'b1;
            if (cal) begin
              if (err_seen_reg || no_ref) begin
                cal_err <= 1'b1;
              end else if (!mode[0]) begin
                ofs_coef <= avg;
              end else begin
                gain_coef <= (avg > ofs_coef) ?
                  16'hffff - (avg - ofs_coef) + 16'h0001 : 16'h8000;
              end
            end else begin
              result <= no_ref ? 16'hffff : corr;
            end
          end
        end
      end
    end
  end
endmodule

// *** rtl/sdfc_top.v ***
// Sigma-delta back end: two converters behind an AHB-Lite slave.
// Assumes modulator bits and the reference detector are asynchronous.
`timescale 1ns/1ps
`include "sdfc_consts.vh"
module sdfc_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        pri_mod_bit,
  input  wire        aux_mod_bit,
  input  wire        reference_missing_flag,
  output wire        pri_chop_swap,
  output wire        aux_chop_swap,
  output wire        pri_ref_route,
  output wire        aux_ref_route
);
  reg  [7:0]  converter_mode_control;
  reg  [7:0]  filter_rate_word;
  reg  [7:0]  primary_channel_config;
  reg  [7:0]  auxiliary_channel_config;
  reg  [2:0]  sync1_reg, sync2_reg;
  reg         wr_pend_reg;
  reg         mode_new_reg;
  reg  [11:0] wr_addr_reg;
  reg         primary_done_reg, auxiliary_done_reg;
  wire [15:0] pri_res, aux_res, pri_ofs, aux_ofs, pri_gain, aux_gain;
  wire        pri_done, aux_done;
  wire        primary_calibration_error_flag;
  wire        auxiliary_calibration_error_flag;
  wire        no_ref = sync2_reg[2];
  wire [2:0]  mode = converter_mode_control[`SDFC_MODE_MSB:0];
  wire        single_end = mode == `SDFC_MD_SINGLE ||
                           mode[2];
  wire        rd_done = hsel && hready && htrans[1] && !hwrite &&
                        haddr == `SDFC_OFF_STATUS;
  wire        wr_go = hsel && hready && htrans[1] && hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {reference_missing_flag, aux_mod_bit, pri_mod_bit};
      sync2_reg <= sync1_reg;
    end
  end
  sdfc_channel u_pri (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .enable    (converter_mode_control[`SDFC_MODE_POS_PRI_EN]),
    .mode      (mode),
    .unipolar  (primary_channel_config[`SDFC_CFG_POS_UNI]),
    .no_ref    (no_ref),
    .bit_in    (sync2_reg[0]),
    .rate      (filter_rate_word),
    .chop_swap (pri_chop_swap),
    .ref_route (pri_ref_route),
    .result    (pri_res),
    .ofs_coef  (pri_ofs),
    .gain_coef (pri_gain),
    .done      (pri_done),
    .cal_err   (primary_calibration_error_flag)
  );
  sdfc_channel u_aux (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .enable    (converter_mode_control[`SDFC_MODE_POS_AUX_EN]),
    .mode      (mode),
    .unipolar  (auxiliary_channel_config[`SDFC_CFG_POS_UNI]),
    .no_ref    (no_ref),
    .bit_in    (sync2_reg[1]),
    .rate      (filter_rate_word),
    .chop_swap (aux_chop_swap),
    .ref_route (aux_ref_route),
    .result    (aux_res),
    .ofs_coef  (aux_ofs),
    .gain_coef (aux_gain),
    .done      (aux_done),
    .cal_err   (auxiliary_calibration_error_flag)
  );
  // Writes land one cycle after the address phase; a status read clears
  // the done flags, but a new completion in that cycle wins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      mode_new_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      converter_mode_control <= `SDFC_MODE_RST;
      filter_rate_word <= `SDFC_RATE_RST;
      primary_channel_config <= 8'h00;
      auxiliary_channel_config <= 8'h00;
      primary_done_reg <= 1'b0;
      auxiliary_done_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_go;
      mode_new_reg <= wr_pend_reg && wr_addr_reg == `SDFC_OFF_MODE;
      wr_addr_reg <= haddr;
      primary_done_reg <= pri_done | (primary_done_reg & ~rd_done);
      auxiliary_done_reg <= aux_done | (auxiliary_done_reg & ~rd_done);
      // A done from the mode just replaced must not end the new one.
      if ((pri_done | aux_done) && single_end && !mode_new_reg)
        converter_mode_control[`SDFC_MODE_MSB:0] <= `SDFC_MD_IDLE;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `SDFC_OFF_MODE:    converter_mode_control <= hwdata[7:0];
          `SDFC_OFF_RATE:    filter_rate_word <=
                               (hwdata[7:0] < `SDFC_RATE_MIN) ?
                               `SDFC_RATE_MIN : hwdata[7:0];
          `SDFC_OFF_PRI_CFG: primary_channel_config <= hwdata[7:0];
          `SDFC_OFF_AUX_CFG: auxiliary_channel_config <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (haddr)
      `SDFC_OFF_MODE:     rd_next[7:0] = converter_mode_control;
      `SDFC_OFF_STATUS: begin
        rd_next[`SDFC_ST_POS_PRI_DONE] = primary_done_reg;
        rd_next[`SDFC_ST_POS_AUX_DONE] = auxiliary_done_reg;
        rd_next[`SDFC_ST_POS_NOREF] = no_ref;
        rd_next[`SDFC_ST_POS_PRI_ERR] = primary_calibration_error_flag;
        rd_next[`SDFC_ST_POS_AUX_ERR] = auxiliary_calibration_error_flag;
      end
      `SDFC_OFF_RATE:     rd_next[7:0] = filter_rate_word;
      `SDFC_OFF_PRI_CFG:  rd_next[7:0] = primary_channel_config;
      `SDFC_OFF_AUX_CFG:  rd_next[7:0] = auxiliary_channel_config;
      `SDFC_OFF_PRI_DATA: rd_next[15:0] = pri_res;
      `SDFC_OFF_AUX_DATA: rd_next[15:0] = aux_res;
      `SDFC_OFF_PRI_OFS:  rd_next[15:0] = pri_ofs;
      `SDFC_OFF_PRI_GAIN: rd_next[15:0] = pri_gain;
      `SDFC_OFF_AUX_OFS:  rd_next[15:0] = aux_ofs;
      `SDFC_OFF_AUX_GAIN: rd_next[15:0] = aux_gain;
      default:            rd_next = 32'h0000_0000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hsel && hready && htrans[1] && !hwrite)
      hrdata <= rd_next;
  end
endmodule

// *** testbench/sdfc_mod_model.sv ***
// Behavioural modulator pair: first-order density sources for both bits.
// Assumes the bench sets the levels and the DUT gives the chop polarity.
`timescale 1ns/1ps
module sdfc_mod_model (
  input  wire logic       hclk,
  input  wire logic [7:0] pri_level,
  input  wire logic [7:0] aux_level,
  input  wire logic       pri_swap,
  input  wire logic       aux_swap,
  output logic            pri_bit,
  output logic            aux_bit
);
  logic [8:0] pri_acc = 9'h000;
  logic [8:0] aux_acc = 9'h000;
  // Swapped inputs invert the level that the loop sees.
  function automatic logic [8:0] step(input logic [8:0] acc,
                                      input logic [7:0] lvl,
                                      input logic       swp);
    step = {1'b0, acc[7:0]} + {1'b0, swp ? 8'hff - lvl : lvl};
  endfunction
  always @(posedge hclk) begin
    pri_acc <= step(pri_acc, pri_level, pri_swap);
    aux_acc <= step(aux_acc, aux_level, aux_swap);
  end
  assign pri_bit = pri_acc[8];
  assign aux_bit = aux_acc[8];
endmodule

// *** testbench/sdfc_top_props.sv ***
// Checker for the converter back end: bus, routing and chop timing.
// Assumes it is bound to sdfc_top and sees only its ports.
`timescale 1ns/1ps
`include "sdfc_consts.vh"
module sdfc_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        pri_chop_swap,
  input wire        aux_chop_swap,
  input wire        pri_ref_route,
  input wire        aux_ref_route
);
  reg        chop_q;
  reg        route_q;
  reg [11:0] gap;
  wire       toggle = pri_chop_swap ^ chop_q;
  // Counts cycles since the last chop flip or internal calibration start on the primary channel.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chop_q <= 1'b0;
      route_q <= 1'b0;
      gap <= 12'h000;
    end else begin
      chop_q <= pri_chop_swap;
      route_q <= pri_ref_route;
      if (toggle || (pri_ref_route && !route_q))
        gap <= 12'h000;
      else if (gap != 12'hfff)
        gap <= gap + 12'h001;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_s;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence mode_wr_s;
    hsel && hready && htrans[1] && hwrite && haddr == `SDFC_OFF_MODE;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  reset_quiet_a: assert property (disable iff (1'b0)
    !hresetn |-> !pri_chop_swap && !aux_chop_swap && !pri_ref_route)
    else $error("outputs active in reset");
  int_route_a: assert property (
    mode_wr_s ##1 (hwdata[2:1] == 2'b10 && hwdata[5]) |-> ##[1:2] pri_ref_route)
    else $error("internal calibration not routed");
  sys_route_a: assert property (
    mode_wr_s ##1 (hwdata[2:1] == 2'b11)
    |-> ##2 (!pri_ref_route && !aux_ref_route)[*4])
    else $error("system calibration routed internally");
  // A restart drops the chop level at once, so only rising flips are timed.
  chop_gap_a: assert property (toggle && pri_chop_swap |-> gap >= 12'd103)
    else $error("chop flipped faster than fastest rate");
  cal_rate_a: assert property (
    toggle && pri_chop_swap && route_q && pri_ref_route |-> gap >= 12'd2000)
    else $error("calibration not at slowest rate");
  read_hold_a: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
  unmapped_zero_a: assert property (rd_s ##0 haddr == 12'h100 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule
bind sdfc_top sdfc_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pri_chop_swap,
  .aux_chop_swap, .pri_ref_route, .aux_ref_route);

// *** testbench/sdfc_top_tb.sv ***
// Bench for the converter back end: register rows, conversion, calibration.
// Assumes the modulator model and the bound checker are compiled with it.
`timescale 1ns/1ps
module sdfc_top_tb;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } sdfc_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        noref = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [7:0]  plev = 8'h80;
  logic [7:0]  alev = 8'h80;
  wire         rdy;
  wire         pbit;
  wire         abit;
  wire         pswap;
  wire         aswap;
  wire [31:0]  hrdata;
  int          fail_count = 0;
  int          num_checks = 0;
  time         t0;
  sdfc_row_t   rows [14] = '{
    '{1'b0, 12'h008, 32'h0, 32'h45}, '{1'b0, 12'h01c, 32'h0, 32'h8000},
    '{1'b0, 12'h020, 32'h0, 32'h8000}, '{1'b0, 12'h024, 32'h0, 32'h8000},
    '{1'b0, 12'h028, 32'h0, 32'h8000}, '{1'b0, 12'h000, 32'h0, 32'h0},
    '{1'b1, 12'h008, 32'h5, 32'h0}, '{1'b0, 12'h008, 32'h0, 32'hd},
    '{1'b1, 12'h008, 32'hff, 32'h0}, '{1'b0, 12'h008, 32'h0, 32'hff},
    '{1'b1, 12'h00c, 32'h1, 32'h0}, '{1'b0, 12'h00c, 32'h0, 32'h1},
    '{1'b0, 12'h100, 32'h0, 32'h0}, '{1'b1, 12'h008, 32'hd, 32'h0}};
  always #5 hclk = ~hclk;
  sdfc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(),
    .pri_mod_bit(pbit), .aux_mod_bit(abit), .reference_missing_flag(noref),
    .pri_chop_swap(pswap), .aux_chop_swap(aswap), .pri_ref_route(),
    .aux_ref_route());
  sdfc_mod_model model (.hclk(hclk), .pri_level(plev), .aux_level(alev),
    .pri_swap(pswap), .aux_swap(aswap), .pri_bit(pbit), .aux_bit(abit));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task poll(input int b);
    // The first read drops a done left over from the mode just replaced.
    bus(1'b0, 12'h004, 32'h0);
    repeat (9000) begin
      bus(1'b0, 12'h004, 32'h0);
      if (rd[b] === 1'b1) return;
    end
    chk({31'h0, rd[b]}, 32'h1);
  endtask
  task finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rd, rows[i].e);
    end
    $display("register rows done");
    bus(1'b1, 12'h000, 32'h23);
    t0 = $time;
    poll(7);
    chk({31'h0, ($time - t0) >= 2080}, 32'h1);
    noref <= 1'b1;
    repeat (300) @(posedge hclk);
    bus(1'b0, 12'h014, 32'h0);
    chk(rd, 32'hffff);
    $display("conversion test done");
    bus(1'b1, 12'h000, 32'h24);
    t0 = $time;
    poll(7);
    chk({31'h0, ($time - t0) >= 40800}, 32'h1);
    chk({31'h0, rd[3]}, 32'h1);
    bus(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'h8000);
    noref <= 1'b0;
    bus(1'b1, 12'h000, 32'h25);
    poll(7);
    chk({31'h0, rd[3]}, 32'h0);
    bus(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h8000);
    alev <= 8'h20;
    bus(1'b1, 12'h000, 32'h16);
    poll(6);
    bus(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h8000);
    bus(1'b0, 12'h024, 32'h0);
    chk({31'h0, rd !== 32'h8000}, 32'h1);
    alev <= 8'he0;
    bus(1'b1, 12'h000, 32'h17);
    poll(6);
    bus(1'b1, 12'h000, 32'h22);
    poll(7);
    bus(1'b0, 12'h000, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0);
    $display("calibration test done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h8000);
    bus(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h45);
    $display("reset test done");
    finish_test;
  end
endmodule
